// [src/rst_clk_map.vh]
// Constants for the reset, mode capture and clock distribution block
`ifndef RST_CLK_MAP_VH
`define RST_CLK_MAP_VH

// ==========================================================
// Register offsets (word addresses on the plain port)
`define OFF_CLKSEL      8'h00
`define OFF_RSTSTAT     8'h04
`define OFF_IRQSTAT     8'h08
`define OFF_IRQEN       8'h0C
`define OFF_IRQCLR      8'h10
`define OFF_SWRST       8'h14
`define OFF_MODE        8'h18

// ==========================================================
// Clock select fields
`define CS_WDOG_LP      0
`define CS_RTC_LO       1
`define CS_RTC_HI       2
`define CS_AUX_EXT      3
`define CS_TMR_FF       4
`define CS_DBG_FAST     5
`define CS_EXT_OSC      6
`define CLKSEL_RST      8'h00

// Real-time counter source codes
`define RTC_LP          2'b00
`define RTC_EXT         2'b01
`define RTC_INT         2'b10

// ==========================================================
// Reset cause bits
`define RS_POR          0
`define RS_PIN          1
`define RS_WDOG         2
`define RS_SW           3
`define RS_ILL          4
`define RS_LVD          5

// Event bits
`define EV_RESET        0
`define EV_DBG_MODE     1

// ==========================================================
// Timing
`define RST_DRIVE_CYC   34
`define BIT_CLKS        16
`define LP_HZ           1000
`define SYS_HZ          250000000
`define LP_HALF_CYC     (`SYS_HZ / `LP_HZ / 2)

`endif

// [src/rst_mode_clk.v]
// Reset sequencer, mode capture and clock distribution
//
// Notes on behaviour
// - Bus clock is half primary output
// - Low-power 1 kHz clock for watchdog, RTC
// - External reference selectable for RTC, converter, CAN
// - Internal reference selectable for RTC
// - Fixed-frequency clock selectable for every timer
// - Timer external clocks synchronised, at most half bus
// - Debug may select fast local clock
// - After reset run from internal clock
// - Drive reset pin low about 34 cycles
// - Record reset cause in status register
// - During reset mode pin is mode input
// - After reset mode pin becomes debug pin
// - High mode pin at release gives normal
// - Low mode pin at release gives debug
// - Debug bit lasts 16 debug clock cycles
// - Bit timing scales with chosen debug clock
// - Brief driven-high speedup pulses on debug pin
`timescale 1ns/1ps
`include "rst_clk_map.vh"

module rst_mode_clk (
  // Clock and reset
  input  wire       CLK_SYS,
  input  wire       NRST,
  // Register port
  input  wire [7:0] ADDR,
  input  wire [7:0] WDATA,
  input  wire       WR,
  input  wire       RD,
  output reg  [7:0] RDATA,
  output reg        IRQ,
  // Reset sources
  input  wire       RESET_PIN_IN,
  output reg        RESET_PIN_OUT,
  output reg        RESET_PIN_OE_N,
  input  wire [3:0] INT_RESET_REQ,
  output reg        CORE_RESET_N,
  // Background / mode select pin
  input  wire       BKGD_IN,
  output reg        BKGD_OUT,
  output reg        BKGD_OE_N,
  input  wire       DBG_TX_VALID,
  input  wire       DBG_TX_BIT,
  output reg        DBG_BIT_TICK,
  output reg        DEBUG_MODE,
  // Clock sources
  input  wire       EXT_REF_CLK,
  input  wire       INT_REF_CLK,
  input  wire       FIXED_FREQ_CLK,
  input  wire [2:0] TIMER_EXT_CLK,
  // Distributed clocks
  output reg        BUS_CLK,
  output reg        LP_1KHZ_CLK,
  output reg        WDOG_CLK,
  output reg        RTC_CLK,
  output reg        AUX_CLK,
  output reg  [2:0] TIMER_FF_CLK,
  output reg  [2:0] TIMER_EXT_SYNC,
  output reg        DBG_CLK,
  output reg        SYS_CLK_SRC_EXT
);

  // ========================================================
  // Synchronisers: three stages, change once 2nd and 3rd agree
  reg  [2:0] pin_s1_r;
  reg  [2:0] pin_s2_r;
  reg  [2:0] pin_s3_r;
  reg  [2:0] pin_q_r;
  reg  [2:0] tmr_s1_r;
  reg  [2:0] tmr_s2_r;
  reg  [2:0] tmr_s3_r;
  reg  [2:0] tmr_q_r;
  wire [2:0] pin_raw = {EXT_REF_CLK ^ INT_REF_CLK ^ FIXED_FREQ_CLK,
                        BKGD_IN, RESET_PIN_IN};
  integer    i;

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      pin_s1_r <= 3'h7;
      pin_s2_r <= 3'h7;
      pin_s3_r <= 3'h7;
      pin_q_r  <= 3'h7;
      tmr_s1_r <= 3'h0;
      tmr_s2_r <= 3'h0;
      tmr_s3_r <= 3'h0;
      tmr_q_r  <= 3'h0;
    end else begin
      pin_s1_r <= pin_raw;
      pin_s2_r <= pin_s1_r;
      pin_s3_r <= pin_s2_r;
      tmr_s1_r <= TIMER_EXT_CLK;
      tmr_s2_r <= tmr_s1_r;
      tmr_s3_r <= tmr_s2_r;
      for (i = 0; i < 3; i = i + 1) begin
        if (pin_s2_r[i] == pin_s3_r[i])
          pin_q_r[i] <= pin_s3_r[i];
        if (tmr_s2_r[i] == tmr_s3_r[i])
          tmr_q_r[i] <= tmr_s3_r[i];
      end
    end
  end

  wire rst_pin_low = ~pin_q_r[0];
  wire bkgd_lvl    = pin_q_r[1];

  // ========================================================
  // Reset sequencer
  localparam [2:0] ST_POR   = 3'b001;
  localparam [2:0] ST_DRIVE = 3'b010;
  localparam [2:0] ST_RUN   = 3'b100;

  reg  [2:0] state_r;
  reg  [5:0] drv_cnt_r;
  reg  [5:0] cause_r;
  reg  [7:0] clksel_r;
  reg  [1:0] irq_stat_r;
  reg  [1:0] irq_en_r;
  reg        sw_rst_r;
  reg        release_r;
  reg        bkgd_dbg_r;
  wire [5:0] cause_now = {INT_RESET_REQ[3], INT_RESET_REQ[2], sw_rst_r,
                          INT_RESET_REQ[0] | INT_RESET_REQ[1],
                          rst_pin_low, 1'b0};
  wire       any_req   = |cause_now;
  wire       rst_enter = (state_r == ST_RUN) && any_req;
  wire       drv_done  = (drv_cnt_r == 6'd`RST_DRIVE_CYC - 6'd1);

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      state_r        <= ST_POR;
      drv_cnt_r      <= 6'h00;
      cause_r        <= 6'h01;
      release_r      <= 1'b0;
      RESET_PIN_OUT  <= 1'b0;
      RESET_PIN_OE_N <= 1'b1;
      CORE_RESET_N   <= 1'b0;
    end else begin
      release_r <= 1'b0;
      case (state_r)
        ST_POR: begin
          state_r        <= ST_DRIVE;
          drv_cnt_r      <= 6'h00;
          RESET_PIN_OE_N <= 1'b0;
        end
        ST_DRIVE: begin
          RESET_PIN_OE_N <= 1'b0;
          drv_cnt_r      <= drv_cnt_r + 6'd1;
          if (drv_done) begin
            RESET_PIN_OE_N <= 1'b1;
            // Hold until pin and all sources let go
            if (!any_req) begin
              state_r      <= ST_RUN;
              CORE_RESET_N <= 1'b1;
              release_r    <= 1'b1;
            end else
              drv_cnt_r <= drv_cnt_r;
          end
        end
        ST_RUN: begin
          if (any_req) begin
            state_r        <= ST_DRIVE;
            drv_cnt_r      <= 6'h00;
            cause_r        <= cause_now;
            CORE_RESET_N   <= 1'b0;
            RESET_PIN_OE_N <= 1'b0;
          end
        end
        default: state_r <= ST_POR;
      endcase
    end
  end

  // ========================================================
  // Mode capture and debug pin function
  reg [3:0] bit_cnt_r;
  reg       dbg_div_r;
  reg       speed_r;
  // Kept as integers so the 16 count cannot wrap in a 4-bit literal
  localparam integer BIT_LAST = `BIT_CLKS - 1;
  localparam integer BIT_HALF = `BIT_CLKS / 2 - 1;

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      DEBUG_MODE   <= 1'b0;
      bkgd_dbg_r   <= 1'b0;
      BKGD_OUT     <= 1'b1;
      BKGD_OE_N    <= 1'b1;
      bit_cnt_r    <= 4'h0;
      dbg_div_r    <= 1'b0;
      speed_r      <= 1'b0;
      DBG_BIT_TICK <= 1'b0;
    end else begin
      DBG_BIT_TICK <= 1'b0;
      // Debug clock: system rate or slow bus rate per clock select
      dbg_div_r <= ~dbg_div_r;
      // Let go of the pin on the very edge the core enters reset
      if (!CORE_RESET_N || rst_enter) begin
        bkgd_dbg_r <= 1'b0;
        BKGD_OE_N  <= 1'b1;
        BKGD_OUT   <= 1'b1;
        bit_cnt_r  <= 4'h0;
        speed_r    <= 1'b0;
      end else begin
        if (release_r) begin
          DEBUG_MODE <= ~bkgd_lvl;
          bkgd_dbg_r <= 1'b1;
        end
        if (bkgd_dbg_r && (clksel_r[`CS_DBG_FAST] || dbg_div_r)) begin
          bit_cnt_r <= bit_cnt_r + 4'd1;
          speed_r   <= 1'b0;
          if (bit_cnt_r == BIT_LAST[3:0]) begin
            DBG_BIT_TICK <= 1'b1;
            // Bit start: drive low for a zero
            BKGD_OE_N <= ~(DBG_TX_VALID & ~DBG_TX_BIT);
            BKGD_OUT  <= 1'b0;
          end else if (bit_cnt_r == BIT_HALF[3:0]) begin
            if (!BKGD_OE_N) begin
              BKGD_OUT <= 1'b1;
              speed_r  <= 1'b1;
            end
          end else if (speed_r) begin
            BKGD_OE_N <= 1'b1;
            BKGD_OUT  <= 1'b1;
          end
        end
      end
    end
  end

  // ========================================================
  // Clock generation and selection
  reg [17:0] lp_cnt_r;
  localparam integer LP_HALF = `LP_HALF_CYC;

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      BUS_CLK         <= 1'b0;
      lp_cnt_r        <= 18'h0_0000;
      LP_1KHZ_CLK     <= 1'b0;
      WDOG_CLK        <= 1'b0;
      RTC_CLK         <= 1'b0;
      AUX_CLK         <= 1'b0;
      TIMER_FF_CLK    <= 3'h0;
      TIMER_EXT_SYNC  <= 3'h0;
      DBG_CLK         <= 1'b0;
      SYS_CLK_SRC_EXT <= 1'b0;
    end else begin
      BUS_CLK <= ~BUS_CLK;
      if (lp_cnt_r == LP_HALF[17:0] - 18'd1) begin
        lp_cnt_r    <= 18'h0_0000;
        LP_1KHZ_CLK <= ~LP_1KHZ_CLK;
      end else
        lp_cnt_r <= lp_cnt_r + 18'd1;
      WDOG_CLK <= clksel_r[`CS_WDOG_LP] ? LP_1KHZ_CLK : BUS_CLK;
      case (clksel_r[`CS_RTC_HI:`CS_RTC_LO])
        `RTC_EXT: RTC_CLK <= EXT_REF_CLK;
        `RTC_INT: RTC_CLK <= INT_REF_CLK;
        default:  RTC_CLK <= LP_1KHZ_CLK;
      endcase
      AUX_CLK <= clksel_r[`CS_AUX_EXT] ? EXT_REF_CLK : BUS_CLK;
      TIMER_FF_CLK <= clksel_r[`CS_TMR_FF] ?
                      {3{FIXED_FREQ_CLK}} : {3{BUS_CLK}};
      TIMER_EXT_SYNC <= tmr_q_r;
      DBG_CLK <= clksel_r[`CS_DBG_FAST] ? ~DBG_CLK : BUS_CLK;
      // Internal clock until software picks the oscillator
      SYS_CLK_SRC_EXT <= CORE_RESET_N & clksel_r[`CS_EXT_OSC];
    end
  end

  // ========================================================
  // Registers and interrupt
  wire [1:0] ev_set = {release_r & ~bkgd_lvl, release_r};

  always @(posedge CLK_SYS) begin
    if (!NRST) begin
      clksel_r   <= `CLKSEL_RST;
      irq_stat_r <= 2'h0;
      irq_en_r   <= 2'h0;
      sw_rst_r   <= 1'b0;
      RDATA      <= 8'h00;
      IRQ        <= 1'b0;
    end else begin
      sw_rst_r <= 1'b0;
      if (!CORE_RESET_N)
        clksel_r <= `CLKSEL_RST;
      if (WR) begin
        if (ADDR == `OFF_CLKSEL)
          clksel_r <= WDATA;
        else if (ADDR == `OFF_IRQEN)
          irq_en_r <= WDATA[1:0];
        else if (ADDR == `OFF_SWRST)
          sw_rst_r <= WDATA[0];
      end
      // Set wins over a clear in the same cycle
      if (WR && ADDR == `OFF_IRQCLR)
        irq_stat_r <= (irq_stat_r & ~WDATA[1:0]) | ev_set;
      else
        irq_stat_r <= irq_stat_r | ev_set;
      IRQ <= |((irq_stat_r | ev_set) & irq_en_r);
      RDATA <= 8'h00;
      if (RD) begin
        if (ADDR == `OFF_CLKSEL)
          RDATA <= clksel_r;
        else if (ADDR == `OFF_RSTSTAT)
          RDATA <= {2'b00, cause_r};
        else if (ADDR == `OFF_IRQSTAT)
          RDATA <= {6'h00, irq_stat_r};
        else if (ADDR == `OFF_IRQEN)
          RDATA <= {6'h00, irq_en_r};
        else if (ADDR == `OFF_MODE)
          RDATA <= {6'h00, bkgd_dbg_r, DEBUG_MODE};
        else
          RDATA <= 8'h00;
      end
    end
  end

endmodule

// [test/dbg_tool_model.sv]
// Debug tool model on the mode pin and the reset line
`timescale 1ns/1ps
module dbg_tool_model (
  // Commands from the bench
  input  wire clk,
  input  wire hold_mode_low,
  input  wire want_reset,
  // Open-drain drives, low while pulling
  output reg  mode_oe_n,
  output reg  rst_oe_n
);
  // Pulls low only; the pull-ups give the high level when released
  always @(posedge clk) begin
    mode_oe_n <= !hold_mode_low;
    rst_oe_n  <= !want_reset;
  end
endmodule

// [test/rst_clk_properties.sv]
// Checker for the reset, mode and clock block
`timescale 1ns/1ps
module rst_clk_properties (
  // Watched ports
  input wire CLK_SYS,
  input wire NRST,
  input wire RESET_PIN_IN,
  input wire RESET_PIN_OE_N,
  input wire CORE_RESET_N,
  input wire BKGD_OUT,
  input wire BKGD_OE_N,
  input wire DBG_BIT_TICK,
  input wire DEBUG_MODE,
  input wire BUS_CLK,
  input wire SYS_CLK_SRC_EXT
);
  // ==========================================================
  // Helper counters
  reg [5:0] lo_r;
  reg [5:0] gap_r;
  // Gap saturates so the first tick after a reset is not judged
  always @(posedge CLK_SYS) begin
    lo_r <= RESET_PIN_OE_N ? 6'h00 : lo_r + 6'h01;
    if (!NRST || !CORE_RESET_N)
      gap_r <= 6'h3F;
    else if (DBG_BIT_TICK)
      gap_r <= 6'h01;
    else if (gap_r != 6'h3F)
      gap_r <= gap_r + 6'h01;
  end
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (!NRST);
  // ==========================================================
  // Properties
  a_bus_half_rate: assert property (
    $past(NRST) |-> BUS_CLK != $past(BUS_CLK))
    else $error("bus clock missed a toggle");
  a_drive_low_len: assert property (
    $rose(RESET_PIN_OE_N) |-> lo_r == 6'h22)
    else $error("reset pin drive length wrong");
  a_pin_request: assert property (
    $fell(RESET_PIN_IN) && CORE_RESET_N |-> ##[1:6] !RESET_PIN_OE_N)
    else $error("pin reset request ignored");
  a_mode_input: assert property (
    !CORE_RESET_N |-> BKGD_OE_N)
    else $error("mode pin driven during reset");
  a_mode_held: assert property (
    CORE_RESET_N && $past(CORE_RESET_N) && $past(CORE_RESET_N, 3)
    |-> $stable(DEBUG_MODE)) else $error("mode changed while running");
  a_speedup_brief: assert property (
    !BKGD_OE_N && BKGD_OUT |-> ##[1:2] BKGD_OE_N)
    else $error("high drive on mode pin too long");
  a_int_clock_first: assert property (
    $rose(CORE_RESET_N) |-> !SYS_CLK_SRC_EXT)
    else $error("external clock in use after reset");
  a_bit_spacing: assert property (
    DBG_BIT_TICK |-> gap_r >= 6'h10)
    else $error("debug bit shorter than sixteen clocks");
  c_pin_drive: cover property ($rose(RESET_PIN_OE_N));
  c_debug_entry: cover property ($rose(DEBUG_MODE));
  c_fast_bit: cover property (DBG_BIT_TICK && gap_r == 6'h10);
endmodule

bind rst_mode_clk rst_clk_properties u_props (
  .CLK_SYS(CLK_SYS), .NRST(NRST), .RESET_PIN_IN(RESET_PIN_IN),
  .RESET_PIN_OE_N(RESET_PIN_OE_N), .CORE_RESET_N(CORE_RESET_N),
  .BKGD_OUT(BKGD_OUT), .BKGD_OE_N(BKGD_OE_N),
  .DBG_BIT_TICK(DBG_BIT_TICK), .DEBUG_MODE(DEBUG_MODE),
  .BUS_CLK(BUS_CLK), .SYS_CLK_SRC_EXT(SYS_CLK_SRC_EXT));

// [test/testbench.sv]
// Self-checking bench for the reset, mode and clock block
`timescale 1ns/1ps
`include "rst_clk_map.vh"
module testbench;
  // ==========================================================
  // Stimulus and wiring
  reg        clk = 1'b0;
  reg        nrst = 1'b0;
  reg  [7:0] addr = 8'h00;
  reg  [7:0] wdata = 8'h00;
  reg        wr = 1'b0;
  reg        rd = 1'b0;
  reg        rd_d = 1'b0;
  reg  [3:0] ireq = 4'h0;
  reg  [1:0] tx = 2'b00;
  reg  [2:0] src = 3'h0;
  reg  [2:0] tmr = 3'h0;
  reg        hold = 1'b0;
  reg        prst = 1'b0;
  reg [15:0] exp_q[$];
  integer    error_cnt = 0;
  integer    tests_run = 0;
  integer    i, n;
  wire [7:0] rdata;
  wire [2:0] tff, tsync;
  wire       irq, p_out, p_oe_n, core_n, b_out, b_oe_n, t_rst_n, t_bk_n;
  wire       tick, dmode, rtc, aux, osc, dbgc;
  reg        d0;
  wire       pin = (p_oe_n | p_out) & t_rst_n;
  wire       bkgd = (b_oe_n | b_out) & t_bk_n;
  rst_mode_clk u_dut (
    .CLK_SYS(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
    .RD(rd), .RDATA(rdata), .IRQ(irq), .RESET_PIN_IN(pin),
    .RESET_PIN_OUT(p_out), .RESET_PIN_OE_N(p_oe_n), .INT_RESET_REQ(ireq),
    .CORE_RESET_N(core_n), .BKGD_IN(bkgd), .BKGD_OUT(b_out),
    .BKGD_OE_N(b_oe_n), .DBG_TX_VALID(tx[1]), .DBG_TX_BIT(tx[0]),
    .DBG_BIT_TICK(tick), .DEBUG_MODE(dmode), .EXT_REF_CLK(src[0]),
    .INT_REF_CLK(src[1]), .FIXED_FREQ_CLK(src[2]), .TIMER_EXT_CLK(tmr),
    .BUS_CLK(), .LP_1KHZ_CLK(), .WDOG_CLK(), .RTC_CLK(rtc), .AUX_CLK(aux),
    .TIMER_FF_CLK(tff), .TIMER_EXT_SYNC(tsync), .DBG_CLK(dbgc),
    .SYS_CLK_SRC_EXT(osc));
  dbg_tool_model u_tool (.clk(clk), .hold_mode_low(hold),
    .want_reset(prst), .mode_oe_n(t_bk_n), .rst_oe_n(t_rst_n));
  always #2 clk = ~clk;
  always @(posedge clk) tx <= 2'($urandom);
  // ==========================================================
  // Checking and bus tasks
  task end_of_test;
    begin
      $display("checks %0d, mismatches %0d", tests_run, error_cnt);
      if (error_cnt == 0 && tests_run > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  task cmp8(input [7:0] got, input [7:0] exp);
    begin
      tests_run = tests_run + 1;
      if (got !== exp) begin
        error_cnt = error_cnt + 1;
        $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
    end
  endtask
  task cmp1(input got, input exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task stp(input integer k);
    repeat (k) @(posedge clk);
  endtask
  task wr8(input [7:0] a, input [7:0] d);
    begin
      addr <= a;
      wdata <= d;
      wr <= 1'b1;
      stp(1);
      wr <= 1'b0;
      stp(1);
    end
  endtask
  task rd8(input [7:0] a, input [7:0] m, input [7:0] e);
    begin
      exp_q.push_back({m, e});
      addr <= a;
      rd <= 1'b1;
      stp(1);
      rd <= 1'b0;
      stp(1);
    end
  endtask
  always @(posedge clk) begin : mon
    reg [15:0] e;
    rd_d <= rd;
    if (rd_d) begin
      e = exp_q.pop_front();
      cmp8(rdata & e[15:8], e[7:0]);
    end
  end
  task wait_run;
    begin
      stp(8);
      n = 0;
      while (core_n !== 1'b1 && n < 200) begin
        stp(1);
        n = n + 1;
      end
      if (n == 200)
        error_cnt = error_cnt + 1;
      stp(4);
    end
  endtask
  // First gap after a select change may be partial, so time the second
  task gap_of(input [7:0] sel, input [7:0] exp);
    begin
      wr8(`OFF_CLKSEL, sel);
      repeat (2) begin
        n = 0;
        stp(1);
        while (tick !== 1'b1 && n < 80) begin
          stp(1);
          n = n + 1;
        end
      end
      cmp8(8'(n + 1), exp);
    end
  endtask
  // ==========================================================
  // Tests
  initial begin
    #40000;
    error_cnt = error_cnt + 1;
    end_of_test;
  end
  initial begin
    n = $urandom(77);
    stp(12);
    nrst <= 1'b1;
    wait_run;
    rd8(`OFF_RSTSTAT, 8'hFF, 8'h01);
    rd8(`OFF_MODE, 8'hFF, 8'h02);
    rd8(`OFF_CLKSEL, 8'hFF, `CLKSEL_RST);
    cmp1(osc, 1'b0);
    cmp1(dmode, 1'b0);
    $display("test done: power-up");
    for (i = 0; i < 4; i = i + 1) begin
      src <= 3'($urandom);
      tmr <= 3'($urandom);
      wr8(`OFF_CLKSEL, 8'h02);
      stp(6);
      cmp1(rtc, src[0]);
      cmp8({5'h00, tsync}, {5'h00, tmr});
      wr8(`OFF_CLKSEL, 8'h1C);
      stp(6);
      cmp1(rtc, src[1]);
      cmp1(aux, src[0]);
      cmp8({5'h00, tff}, {5'h00, {3{src[2]}}});
    end
    gap_of(8'h20, 8'h10);
    d0 = dbgc;
    stp(1);
    cmp1(dbgc, ~d0);
    gap_of(8'h00, 8'h20);
    $display("test done: clocks");
    hold <= 1'b1;
    prst <= 1'b1;
    n = 0;
    while (p_oe_n !== 1'b0 && n < 20) begin
      stp(1);
      n = n + 1;
    end
    prst <= 1'b0;
    n = 0;
    while (p_oe_n === 1'b0 && n < 60) begin
      stp(1);
      n = n + 1;
    end
    cmp8(8'(n), 8'h22);
    cmp1(p_out, 1'b0);
    wait_run;
    hold <= 1'b0;
    stp(2);
    cmp1(dmode, 1'b1);
    rd8(`OFF_MODE, 8'hFF, 8'h03);
    rd8(`OFF_RSTSTAT, 8'hFF, 8'h02);
    hold <= 1'b1;
    stp(4);
    hold <= 1'b0;
    stp(4);
    cmp1(dmode, 1'b1);
    $display("test done: pin reset and mode");
    for (i = 0; i < 5; i = i + 1) begin
      if (i < 4)
        ireq <= 4'h1 << i;
      else
        wr8(`OFF_SWRST, 8'h01);
      stp(1);
      ireq <= 4'h0;
      wait_run;
      rd8(`OFF_RSTSTAT, 8'hFF, 8'h01 << (i < 2 ? `RS_WDOG : i == 2 ?
        `RS_ILL : i == 3 ? `RS_LVD : `RS_SW));
      cmp1(dmode, 1'b0);
    end
    $display("test done: internal resets");
    rd8(`OFF_IRQSTAT, 8'h01, 8'h01);
    wr8(`OFF_IRQEN, 8'h00);
    stp(2);
    cmp1(irq, 1'b0);
    wr8(`OFF_IRQEN, 8'h01);
    stp(2);
    cmp1(irq, 1'b1);
    wr8(`OFF_IRQCLR, 8'h01);
    stp(2);
    cmp1(irq, 1'b0);
    rd8(`OFF_IRQSTAT, 8'h01, 8'h00);
    wr8(`OFF_RSTSTAT, 8'hFF);
    rd8(`OFF_RSTSTAT, 8'hFF, 8'h08);
    rd8(8'h1C, 8'hFF, 8'h00);
    stp(2);
    $display("test done: interrupt and map");
    end_of_test;
  end
endmodule
